//--- hdl/pcm_serial_port.sv
// serial audio output port: format registers, channel 0 routing, AHB-Lite slave
// What this block does
// - unassigned slots float when the tristate bit is 1, are driven low when 0
// - slot width code 00, 01, 10 gives 32, 16, 24 bit clocks
// - format code 000 is I2S one-bit delay, 001 left-justified no delay
// - format codes 010, 011, 100 delay first data bit by 8, 12, 16
// - mode bit 0 is stereo framing, 1 is multi-slot framing, reset multi-slot
// - frame clock polarity bit 1 inverts the frame clock sense
// - bit clock polarity 0 host captures on rising, 1 on falling edge
// - four-bit index picks slot 0 to 15 carrying channel 0
// - channel 0 drive bit 0 floats the output during its slot
// - one pair enable bit gates channel 0, set at reset
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"

module pcm_serial_port
   import pcm_pkg::*;
#(
   parameter int SAMPLE_W   = 24,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic                CLK_SYS_I,      // 40 MHz system clock
   input  wire logic                ARST_N_I,       // async reset, low
   input  wire logic                HSEL_I,         // slave select
   input  wire logic [31:0]         HADDR_I,        // byte address
   input  wire logic [1:0]          HTRANS_I,       // transfer type
   input  wire logic                HWRITE_I,       // write when high
   input  wire logic [2:0]          HSIZE_I,        // transfer size
   input  wire logic [31:0]         HWDATA_I,       // write data
   input  wire logic                HREADY_I,       // bus ready
   output logic      [31:0]         HRDATA_O,       // read data
   output logic                     HREADYOUT_O,    // slave ready
   output logic                     HRESP_O,        // response, always okay
   input  wire logic                BCLK_I,         // bit clock from host
   input  wire logic                FCLK_I,         // frame clock from host
   output logic                     SDATA_O,        // serial data out
   output logic                     SDATA_OE_N_O,   // output enable, low drives
   input  wire logic [SAMPLE_W-1:0] SAMPLE_I,       // channel 0 sample word
   input  wire logic                SAMPLE_VALID_I, // sample offered
   output logic                     SAMPLE_READY_O  // sample accepted
);

   localparam pcm_top_s TOP_RST = '{
      en:      `PCM_RST_ENABLES,
      fmt:     `PCM_RST_FMT,
      pol:     `PCM_RST_POL,
      c0:      `PCM_RST_C0,
      ap_idx:  `PCM_IDX_NONE,
      phase:   PH_WAIT,
      oe_n:    1'b1,
      default: '0
   };

   generate
      if (SAMPLE_W < 16 || SAMPLE_W > 32) begin : g_chk
         $error("pcm_serial_port: SAMPLE_W must lie in 16..32");
      end
   endgenerate

   pcm_top_s q;
   pcm_top_s d;
   logic     pop;
   logic [1:0] clk_lvl;
   logic [1:0] clk_edge;

   pcm_stream_if #(.W(SAMPLE_W)) in_s ();
   pcm_stream_if #(.W(SAMPLE_W)) out_s ();

   assign in_s.valid     = SAMPLE_VALID_I;
   assign in_s.data      = SAMPLE_I;
   assign SAMPLE_READY_O = in_s.ready;
   assign out_s.ready    = pop;

   pcm_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i    (CLK_SYS_I),
      .arst_n_i (ARST_N_I),
      .wr       (in_s),
      .rd       (out_s)
   );

   // bit 0 carries the bit clock, bit 1 the frame clock
   pcm_sync #(
      .W (2)
   ) u_sync (
      .clk_i    (CLK_SYS_I),
      .arst_n_i (ARST_N_I),
      .din_i    ({FCLK_I, BCLK_I}),
      .lvl_o    (clk_lvl),
      .edge_o   (clk_edge)
   );

   // bit clocks per slot
   function automatic logic [5:0] slot_len(input logic [1:0] code);
      case (code)
         `PCM_WCODE_16: slot_len = `PCM_SLOT_LEN_16;
         `PCM_WCODE_24: slot_len = `PCM_SLOT_LEN_24;
         default:       slot_len = `PCM_SLOT_LEN_32;
      endcase
   endfunction : slot_len

   // bit clocks from frame clock transition to first data bit
   function automatic logic [4:0] data_delay(input logic [2:0] code);
      case (code)
         `PCM_DCODE_LJ: data_delay = `PCM_DLY_LJ;
         `PCM_DCODE_8:  data_delay = `PCM_DLY_8;
         `PCM_DCODE_12: data_delay = `PCM_DLY_12;
         `PCM_DCODE_16: data_delay = `PCM_DLY_16;
         default:       data_delay = `PCM_DLY_I2S;
      endcase
   endfunction : data_delay

   function automatic logic [31:0] read_word(input logic [7:0] idx,
                                             input pcm_top_s   s,
                                             input logic [7:0] stat);
      case (idx)
         `PCM_IDX_ENABLES: read_word = {24'h000000, s.en};
         `PCM_IDX_FMT:     read_word = {24'h000000, s.fmt};
         `PCM_IDX_POL:     read_word = {24'h000000, s.pol};
         `PCM_IDX_C0:      read_word = {24'h000000, s.c0};
         `PCM_IDX_STATUS:  read_word = {24'h000000, stat};
         default:          read_word = 32'h00000000;
      endcase
   endfunction : read_word

   logic        launch;
   logic        capture;
   logic        f_rise;
   logic        f_fall;
   logic        start;
   logic        tdm;
   logic        mine;
   logic [5:0]  len;
   logic [4:0]  dly0;
   logic [31:0] word;
   logic [7:0]  stat;
   logic [7:0]  idx;
   logic        addr_ok;

   always_comb begin
      d       = q;
      pop     = 1'b0;
      word    = 32'h00000000;
      len     = slot_len(q.fmt[`PCM_FMT_WIDTH]);
      dly0    = data_delay(q.fmt[`PCM_FMT_DELAY]);
      tdm     = q.fmt[`PCM_FMT_MODE];
      // data changes on the edge opposite to the host's capture edge
      launch  = clk_edge[0] && (clk_lvl[0] == q.pol[`PCM_POL_BCLK]);
      capture = clk_edge[0] && (clk_lvl[0] != q.pol[`PCM_POL_BCLK]);
      f_rise  = q.fclk_cap && !q.fclk_prev;
      f_fall  = !q.fclk_cap && q.fclk_prev;
      // multi-slot frames start on the rising sense; stereo uses both edges
      start   = tdm ? f_rise : (f_rise || f_fall);
      mine    = 1'b0;

      // frame clock is taken mid-bit so it is stable against the launch edge
      if (capture) begin
         d.fclk_cap = clk_lvl[1] ^ q.pol[`PCM_POL_FCLK];
      end

      if (launch) begin
         d.fclk_prev = q.fclk_cap;
         if (start) begin
            d.slot = (!tdm && f_rise) ? 4'h1 : 4'h0;
            d.bit_n = 6'h00;
            if (dly0 == 5'h00) begin
               d.phase = PH_DATA;
            end else begin
               d.phase = PH_DELAY;
               d.dly   = dly0 - 5'h01;
            end
         end else begin
            unique case (q.phase)
               PH_WAIT: begin
                  d.phase = PH_WAIT;
               end
               PH_DELAY: begin
                  if (q.dly == 5'h00) begin
                     d.phase = PH_DATA;
                     d.bit_n = 6'h00;
                  end else begin
                     d.dly = q.dly - 5'h01;
                  end
               end
               PH_DATA: begin
                  if (q.bit_n == len - 6'h01) begin
                     d.bit_n = 6'h00;
                     if (tdm) begin
                        d.slot = q.slot + 4'h1;
                     end else begin
                        d.phase = PH_WAIT;
                     end
                  end else begin
                     d.bit_n = q.bit_n + 6'h01;
                  end
               end
            endcase
         end

         // channel 0 owns the slot only while its pair is enabled
         mine = (d.phase == PH_DATA) && (d.slot == q.c0[`PCM_C0_SLOT])
                && q.en[`PCM_EN_PAIR0];
         if (mine && d.bit_n == 6'h00) begin
            if (out_s.valid) begin
               // left aligned; a full 32-bit sample needs no padding
               word = 32'(out_s.data) << (32 - SAMPLE_W);
               pop  = 1'b1;
            end
            d.sdata = word[31];
            d.shift = {word[30:0], 1'b0};
         end else if (mine) begin
            d.sdata = q.shift[31];
            d.shift = {q.shift[30:0], 1'b0};
         end else begin
            d.sdata = 1'b0;
         end

         if (mine) begin
            d.oe_n = !q.c0[`PCM_C0_DRV];
         end else begin
            d.oe_n = q.fmt[`PCM_FMT_HIZ];
         end
         // a floating line carries no stale sample bit
         if (d.oe_n) begin
            d.sdata = 1'b0;
         end
      end

      // data phase of a write: only documented bits take the value
      if (q.ap_valid && q.ap_write) begin
         case (q.ap_idx)
            `PCM_IDX_ENABLES: d.en  = HWDATA_I[7:0] & `PCM_WMASK_ENABLES;
            `PCM_IDX_FMT:     d.fmt = HWDATA_I[7:0] & `PCM_WMASK_FMT;
            `PCM_IDX_POL:     d.pol = HWDATA_I[7:0] & `PCM_WMASK_POL;
            `PCM_IDX_C0:      d.c0  = HWDATA_I[7:0] & `PCM_WMASK_C0;
            default:          d.en  = d.en;
         endcase
      end

      // address phase
      addr_ok    = (HADDR_I[31:10] == 22'h000000) && (HADDR_I[1:0] == 2'b00)
                   && (HSIZE_I == `PCM_HSIZE_WORD);
      idx        = addr_ok ? HADDR_I[9:2] : `PCM_IDX_NONE;
      stat       = {q.slot, !q.oe_n, (q.phase == PH_DATA), !in_s.ready, !out_s.valid};
      d.ap_valid = HSEL_I && HTRANS_I[1] && HREADY_I;
      d.ap_write = HWRITE_I;
      d.ap_idx   = idx;
      if (d.ap_valid && !HWRITE_I) begin
         // read sees a write completing in this same cycle
         d.hrdata = read_word(idx, d, stat);
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   assign HRDATA_O     = q.hrdata;
   assign HREADYOUT_O  = 1'b1;
   assign HRESP_O      = 1'b0;
   assign SDATA_O      = q.sdata;
   assign SDATA_OE_N_O = q.oe_n;

endmodule : pcm_serial_port

`default_nettype wire

//--- hdl/pcm_map.svh
// register indices, field positions, reset values and format codes of the serial port
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// register index; byte address is four times the index
`define PCM_IDX_ENABLES  8'h04
`define PCM_IDX_FMT      8'h07
`define PCM_IDX_POL      8'h08
`define PCM_IDX_C0       8'h09
`define PCM_IDX_STATUS   8'h0c
`define PCM_IDX_NONE     8'hff

`define PCM_RST_ENABLES  8'h01
`define PCM_RST_FMT      8'h41
`define PCM_RST_POL      8'h00
`define PCM_RST_C0       8'h01

// writable bits of each register
`define PCM_WMASK_ENABLES 8'h01
`define PCM_WMASK_FMT     8'h7f
`define PCM_WMASK_POL     8'h03
`define PCM_WMASK_C0      8'hf1

`define PCM_EN_PAIR0     0
`define PCM_FMT_HIZ      6
`define PCM_FMT_WIDTH    5:4
`define PCM_FMT_DELAY    3:1
`define PCM_FMT_MODE     0
`define PCM_POL_FCLK     1
`define PCM_POL_BCLK     0
`define PCM_C0_SLOT      7:4
`define PCM_C0_DRV       0

`define PCM_WCODE_32     2'b00
`define PCM_WCODE_16     2'b01
`define PCM_WCODE_24     2'b10
`define PCM_SLOT_LEN_32  6'h20
`define PCM_SLOT_LEN_16  6'h10
`define PCM_SLOT_LEN_24  6'h18

`define PCM_DCODE_I2S    3'b000
`define PCM_DCODE_LJ     3'b001
`define PCM_DCODE_8      3'b010
`define PCM_DCODE_12     3'b011
`define PCM_DCODE_16     3'b100
`define PCM_DLY_I2S      5'h01
`define PCM_DLY_LJ       5'h00
`define PCM_DLY_8        5'h08
`define PCM_DLY_12       5'h0c
`define PCM_DLY_16       5'h10

`define PCM_HSIZE_WORD   3'b010

`endif

//--- hdl/pcm_pkg.sv
// types shared by the serial port modules
`default_nettype none
package pcm_pkg;

   typedef enum logic [1:0] {
      PH_WAIT,
      PH_DELAY,
      PH_DATA
   } pcm_phase_e;

   typedef struct packed {
      logic [7:0]  en;
      logic [7:0]  fmt;
      logic [7:0]  pol;
      logic [7:0]  c0;
      logic        ap_valid;
      logic        ap_write;
      logic [7:0]  ap_idx;
      logic [31:0] hrdata;
      logic        fclk_cap;
      logic        fclk_prev;
      pcm_phase_e  phase;
      logic [4:0]  dly;
      logic [5:0]  bit_n;
      logic [3:0]  slot;
      logic [31:0] shift;
      logic        sdata;
      logic        oe_n;
   } pcm_top_s;

endpackage : pcm_pkg

`default_nettype wire

//--- hdl/pcm_stream_if.sv
// valid/ready word stream between the sample buffer and the serial engine
`timescale 1ns/1ps
`default_nettype none

interface pcm_stream_if #(
   parameter int W = 24
) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : pcm_stream_if

`default_nettype wire

//--- hdl/pcm_sync.sv
// three-flop synchroniser with agreement filter and edge pulse
`timescale 1ns/1ps
`default_nettype none

module pcm_sync #(
   parameter int W = 2
) (
   input  wire logic         clk_i,    // system clock
   input  wire logic         arst_n_i, // async reset, low
   input  wire logic [W-1:0] din_i,    // asynchronous levels
   output logic      [W-1:0] lvl_o,    // filtered level
   output logic      [W-1:0] edge_o    // one-cycle pulse on change
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] edg;
   } pcm_sync_s;

   pcm_sync_s q;
   pcm_sync_s d;

   generate
      if (W < 1) begin : g_chk
         $error("pcm_sync: W must be at least 1");
      end
   endgenerate

   always_comb begin
      d     = q;
      d.s1  = din_i;
      d.s2  = q.s1;
      d.s3  = q.s2;
      // a new level counts only once the second and third stage agree
      d.lvl = (q.s3 & ~(q.s2 ^ q.s3)) | (q.lvl & (q.s2 ^ q.s3));
      d.edg = d.lvl ^ q.lvl;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lvl_o  = q.lvl;
   assign edge_o = q.edg;

endmodule : pcm_sync

`default_nettype wire

//--- hdl/pcm_fifo.sv
// sample buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module pcm_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input  wire logic   clk_i,    // system clock
   input  wire logic   arst_n_i, // async reset, low
   pcm_stream_if.snk   wr,       // filling side
   pcm_stream_if.src   rd        // draining side
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } pcm_fifo_s;

   pcm_fifo_s q;
   pcm_fifo_s d;
   logic      empty;
   logic      full;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
         $error("pcm_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   assign empty    = (q.wp == q.rp);
   assign full     = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (wr.valid && !full) begin
         d.mem[q.wp[AW-1:0]] = wr.data;
         d.wp                = q.wp + 1'b1;
      end
      if (rd.ready && !empty) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : pcm_fifo

`default_nettype wire

//--- test/pcm_serial_port_sva.sv
// concurrent checks on the serial port's bus and line pins
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"

module pcm_serial_port_sva (
   input wire logic        CLK_SYS_I,    // system clock
   input wire logic        ARST_N_I,     // async reset, low
   input wire logic        HSEL_I,       // select
   input wire logic [31:0] HADDR_I,      // address
   input wire logic [1:0]  HTRANS_I,     // transfer type
   input wire logic        HWRITE_I,     // write
   input wire logic [2:0]  HSIZE_I,      // size
   input wire logic [31:0] HWDATA_I,     // write data
   input wire logic        HREADY_I,     // bus ready
   input wire logic [31:0] HRDATA_O,     // read data
   input wire logic        HREADYOUT_O,  // slave ready
   input wire logic        HRESP_O,      // response
   input wire logic        BCLK_I,       // bit clock
   input wire logic        SDATA_O,      // line data
   input wire logic        SDATA_OE_N_O  // line enable, low
);
   logic       bclk_q;
   logic [3:0] idle_q;

   // cycles since the bit clock last moved, saturating
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         bclk_q <= 1'b0;
         idle_q <= 4'h0;
      end else begin
         bclk_q <= BCLK_I;
         idle_q <= (BCLK_I != bclk_q) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
      end
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);

   sequence s_any;
      HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
   endsequence
   sequence s_req(logic w, logic [7:0] i);
      HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I == w
         && HSIZE_I == `PCM_HSIZE_WORD && HADDR_I == {22'h0, i, 2'b00};
   endsequence

   property p_okay;
      HREADYOUT_O && !HRESP_O;
   endproperty
   property p_quiet;
      idle_q == 4'hf |-> $stable(SDATA_O) && $stable(SDATA_OE_N_O);
   endproperty
   property p_float;
      SDATA_OE_N_O |-> !SDATA_O;
   endproperty
   property p_hi;
      s_any |=> HRDATA_O[31:8] == 24'h0;
   endproperty
   property p_fmt;
      s_req(1'b0, `PCM_IDX_FMT) |=> !HRDATA_O[7];
   endproperty
   property p_pol;
      s_req(1'b0, `PCM_IDX_POL) |=> HRDATA_O[7:2] == 6'h0;
   endproperty
   property p_c0;
      s_req(1'b0, `PCM_IDX_C0) |=> HRDATA_O[3:1] == 3'h0;
   endproperty
   property p_unmap;
      s_req(1'b0, 8'h05) |=> HRDATA_O == 32'h0;
   endproperty
   property p_wr_rd;
      s_req(1'b1, `PCM_IDX_POL) ##2 s_req(1'b0, `PCM_IDX_POL)
         |=> HRDATA_O[1:0] == $past(HWDATA_I[1:0], 2);
   endproperty

   a_okay: assert property (p_okay) else $error("bus answer not okay");
   a_quiet: assert property (p_quiet) else $error("line moved, clock idle");
   a_float: assert property (p_float) else $error("floating line not low");
   a_hi: assert property (p_hi) else $error("read high bits set");
   a_fmt: assert property (p_fmt) else $error("format bit 7 set");
   a_pol: assert property (p_pol) else $error("polarity top bits set");
   a_c0: assert property (p_c0) else $error("route bits 3:1 set");
   a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
   a_wr_rd: assert property (p_wr_rd) else $error("polarity readback");
endmodule : pcm_serial_port_sva

`default_nettype wire

//--- test/pcm_host_model.sv
// audio host: makes bit and frame clocks, captures the line per bit
`timescale 1ns/1ps
`default_nettype none

module pcm_host_model (
   input  wire logic       run_i,    // run whole frames
   input  wire logic       bpol_i,   // capture on falling when 1
   input  wire logic       fpol_i,   // inverted frame clock
   input  wire logic       stereo_i, // two-slot framing
   input  wire logic [5:0] width_i,  // bit clocks per slot
   input  wire logic [4:0] nslot_i,  // slots per frame
   input  wire logic       sdata_i,  // line data
   input  wire logic       oe_n_i,   // line enable, low
   output logic            bclk_o,   // bit clock
   output logic            fclk_o    // frame clock
);
   logic sd [0:511];
   logic oe [0:511];
   int   nframe;
   int   len;
   int   n;

   initial begin
      bclk_o = 1'b1;
      fclk_o = 1'b0;
      nframe = 0;
   end

   // clock stands still between frames
   always begin
      wait (run_i);
      // pin edges fall between system clock edges, never on them
      #7;
      len = (stereo_i ? 2 : int'(nslot_i)) * int'(width_i);
      for (n = 0; n < len; n++) begin
         bclk_o = bpol_i;
         fclk_o = fpol_i ^ (stereo_i ? n >= width_i : n < width_i);
         #100;
         bclk_o = ~bpol_i;
         sd[n] = sdata_i;
         oe[n] = oe_n_i;
         #100;
      end
      nframe++;
   end
endmodule : pcm_host_model

`default_nettype wire

//--- test/pcm_serial_port_tb.sv
// register and line tests of the serial audio port
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"

module pcm_serial_port_tb;
   localparam logic [23:0] SMP = 24'ha5c3f1;
   logic        clk;
   logic        arst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        bclk, fclk, sdata, oe_n, sready, svalid;
   logic        run, bpol, fpol, stereo;
   logic [5:0]  width;
   logic [4:0]  nslot;
   logic [31:0] rd;
   logic [15:0] dw;
   int          num_errors, n_tests, p0, first, cnt;
   logic [7:0]  idx_t [5] = '{8'h04, 8'h07, 8'h08, 8'h09, 8'h05};
   logic [7:0]  rst_t [5] = '{8'h01, 8'h41, 8'h00, 8'h01, 8'h00};
   logic [7:0]  msk_t [5] = '{8'h01, 8'h7f, 8'h03, 8'hf1, 8'h00};
   int          dly [5] = '{1, 0, 8, 12, 16};
   int          wb [3] = '{32, 16, 24};

   always #12.5 clk = ~clk;

   pcm_serial_port dut (
      .CLK_SYS_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(`PCM_HSIZE_WORD), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .BCLK_I(bclk), .FCLK_I(fclk), .SDATA_O(sdata), .SDATA_OE_N_O(oe_n),
      .SAMPLE_I(SMP), .SAMPLE_VALID_I(svalid), .SAMPLE_READY_O(sready));

   pcm_host_model host (
      .run_i(run), .bpol_i(bpol), .fpol_i(fpol), .stereo_i(stereo), .width_i(width),
      .nslot_i(nslot), .sdata_i(sdata), .oe_n_i(oe_n), .bclk_o(bclk), .fclk_o(fclk));

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic step;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 64);
      if (k >= 64) begin
         num_errors++;
         give_verdict();
      end
   endtask : step

   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      step();
      htrans <= 2'b00;
      hwdata <= wd;
      step();
      rd = hrdata;
   endtask : ahb

   // program, run two frames, measure the second
   task automatic frame(input logic [7:0] fmt, input logic [7:0] c0, input logic [7:0] pol,
                        input logic [5:0] w, input logic [4:0] ns);
      int f0;
      int k;
      ahb(1'b1, `PCM_IDX_FMT, {24'h0, fmt});
      ahb(1'b1, `PCM_IDX_POL, {24'h0, pol});
      ahb(1'b1, `PCM_IDX_C0, {24'h0, c0});
      width  <= w;
      nslot  <= ns;
      stereo <= !fmt[0];
      bpol   <= pol[0];
      fpol   <= pol[1];
      f0 = host.nframe;
      run <= 1'b1;
      k = 0;
      while (host.nframe < f0 + 2 && k < 20000) begin
         @(posedge clk);
         k++;
         if (host.nframe > f0) run <= 1'b0;
      end
      if (k >= 20000) begin
         num_errors++;
         give_verdict();
      end
      first = -1;
      cnt = 0;
      dw = 16'h0;
      for (int n = 0; n < host.len; n++) begin
         if (host.oe[n] === 1'b0) begin
            if (first < 0) first = n;
            cnt++;
         end
      end
      for (int i = 0; i < 16 && first >= 0 && first + i < 512; i++) dw[15-i] = host.sd[first+i];
   endtask : frame

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      svalid = 1'b0;
      run = 1'b0;
      bpol = 1'b0;
      fpol = 1'b0;
      stereo = 1'b0;
      width = 6'd32;
      nslot = 5'd2;
      num_errors = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         ahb(1'b0, idx_t[i], 32'h0);
         chk(rd, {24'h0, rst_t[i]});
         ahb(1'b1, idx_t[i], 32'hffff_ffff);
         ahb(1'b0, idx_t[i], 32'h0);
         chk(rd, {24'h0, msk_t[i]});
         ahb(1'b1, idx_t[i], {24'h0, rst_t[i]});
      end
      ahb(1'b0, `PCM_IDX_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h1);
      chk({31'h0, sready}, 32'h1);
      svalid <= 1'b1;
      repeat (3) ahb(1'b0, `PCM_IDX_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h2);
      chk({31'h0, sready}, 32'h0);
      frame(8'h43, 8'h01, 8'h00, 6'd32, 5'd2);
      p0 = first;
      chk(32'(cnt), 32'd32);
      chk({16'h0, dw}, {16'h0, SMP[23:8]});
      for (int c = 0; c < 5; c++) begin
         frame(8'h41 | 8'(c << 1), 8'h01, 8'h00, 6'd32, 5'd2);
         chk(32'(first), 32'(p0 + dly[c]));
      end
      for (int w = 0; w < 3; w++) begin
         frame(8'h43 | 8'(w << 4), 8'h01, 8'h00, 6'(wb[w]), 5'd2);
         chk(32'(first), 32'(p0));
         chk(32'(cnt), 32'(wb[w]));
      end
      frame(8'h53, 8'he1, 8'h00, 6'd16, 5'd16);
      chk(32'(first), 32'(p0 + 224));
      frame(8'h43, 8'h00, 8'h00, 6'd32, 5'd2);
      chk(32'(cnt), 32'd0);
      frame(8'h03, 8'h00, 8'h00, 6'd32, 5'd2);
      chk(32'(cnt), 32'd32);
      ahb(1'b1, `PCM_IDX_ENABLES, 32'h0);
      frame(8'h43, 8'h01, 8'h00, 6'd32, 5'd2);
      chk(32'(cnt), 32'd0);
      ahb(1'b1, `PCM_IDX_ENABLES, 32'h1);
      frame(8'h42, 8'h01, 8'h00, 6'd32, 5'd2);
      chk(32'(first), 32'(p0));
      chk(32'(cnt), 32'd32);
      frame(8'h43, 8'h01, 8'h01, 6'd32, 5'd2);
      chk(32'(first), 32'(p0));
      chk({16'h0, dw}, {16'h0, SMP[23:8]});
      frame(8'h43, 8'h01, 8'h02, 6'd32, 5'd2);
      chk(32'(first), 32'(p0));
      give_verdict();
   end
endmodule : pcm_serial_port_tb

bind pcm_serial_port pcm_serial_port_sva u_sva (
   .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
   .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
   .HRESP_O(HRESP_O), .BCLK_I(BCLK_I), .SDATA_O(SDATA_O), .SDATA_OE_N_O(SDATA_OE_N_O));

`default_nettype wire
